// file: pkg/fshr_hot_if.sv
// Carrier between the register bank and the hot comparator
`timescale 1ns/100ps
interface fshr_hot_if;
	import fshr_pkg::*;

	logic [7:0] temperature;
	logic [7:0] threshold;
	fshr_hys_t  hys_code;
	logic       enable;
	logic       hot;

	modport ctrl (
		output temperature,
		output threshold,
		output hys_code,
		output enable,
		input  hot
	);

	modport cmp (
		input  temperature,
		input  threshold,
		input  hys_code,
		input  enable,
		output hot
	);
endinterface

// file: pkg/fshr_pkg.sv
// Constants and types for the fault status and hot hysteresis registers
package fshr_pkg;

	localparam logic [7:0] FSHR_HYS_OFFSET   = 8'h19;
	localparam logic [7:0] FSHR_FAULT_OFFSET = 8'h1A;

	localparam int         FSHR_HYS_W        = 3;
	localparam logic [2:0] FSHR_HYS_RESET    = 3'h0;
	localparam logic [7:0] FSHR_HYS_STEP_DEG = 8'h03;
	localparam logic [7:0] FSHR_HOT_DISABLE  = 8'h00;
	localparam logic [7:0] FSHR_UNMAPPED     = 8'h00;

	localparam int FSHR_BIT_RSVD  = 7;
	localparam int FSHR_BIT_SSOC  = 6;
	localparam int FSHR_BIT_HOT   = 5;
	localparam int FSHR_BIT_OCW   = 4;
	localparam int FSHR_BIT_OTP   = 3;
	localparam int FSHR_BIT_UV    = 2;
	localparam int FSHR_BIT_OV    = 1;
	localparam int FSHR_BIT_OC    = 0;

	typedef logic [FSHR_HYS_W-1:0] fshr_hys_t;

	typedef enum logic {
		FSHR_HOT_RELEASED,
		FSHR_HOT_ASSERTED
	} fshr_hot_e;

endpackage

// file: rtl/fshr_hot_compare.sv
// Hot warning comparator with selectable release hysteresis
`timescale 1ns/100ps
module fshr_hot_compare (
	input  wire logic      clock,
	input  wire logic      reset,
	fshr_hot_if.cmp        hot_bus
);
	import fshr_pkg::*;

	fshr_hot_e  state_r;
	fshr_hot_e  state_nxt;
	logic [7:0] hys_deg;
	logic [8:0] release_sum;
	logic       active;
	logic       at_threshold;
	logic       below_release;

	// Code n selects (n+1) * 3 degC
	assign hys_deg = ({5'h00, hot_bus.hys_code} + 8'h01) * FSHR_HYS_STEP_DEG;
	assign release_sum = {1'b0, hot_bus.temperature} + {1'b0, hys_deg};
	assign active = hot_bus.enable && (hot_bus.threshold != FSHR_HOT_DISABLE);
	assign at_threshold = hot_bus.temperature >= hot_bus.threshold;
	assign below_release = release_sum < {1'b0, hot_bus.threshold};

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			FSHR_HOT_RELEASED: begin
				if (active && at_threshold) begin
					state_nxt = FSHR_HOT_ASSERTED;
				end
			end
			FSHR_HOT_ASSERTED: begin
				if (!active || below_release) begin
					state_nxt = FSHR_HOT_RELEASED;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_r <= FSHR_HOT_RELEASED;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign hot_bus.hot = (state_r == FSHR_HOT_ASSERTED);

	property p_hot_sets;
		@(posedge clock) disable iff (reset)
		(active && at_threshold) |=> hot_bus.hot;
	endproperty
	a_hot_sets: assert property (p_hot_sets)
		else $error("hot warning did not set at threshold");

	property p_hot_holds;
		@(posedge clock) disable iff (reset)
		(hot_bus.hot && active && !below_release) |=> hot_bus.hot;
	endproperty
	a_hot_holds: assert property (p_hot_holds)
		else $error("hot warning released inside hysteresis band");
endmodule

// file: rtl/fshr_regs.sv
// Fault status and hot hysteresis register bank
`timescale 1ns/100ps
module fshr_regs (
	input  wire logic           clock,
	input  wire logic           reset,
	input  wire logic [7:0]     reg_addr,
	input  wire logic           reg_wr_en,
	input  wire logic           reg_rd_en,
	input  wire logic [7:0]     reg_wdata,
	output logic      [7:0]     reg_rdata,
	input  wire logic [7:0]     die_temperature_code,
	input  wire logic [7:0]     hot_threshold_code,
	input  wire logic           hot_threshold_host_control,
	input  wire logic           processor_hot_request,
	input  wire logic           softstart_overcurrent_flag,
	input  wire logic           overcurrent_warning_event,
	input  wire logic           overtemperature_flag,
	input  wire logic           undervoltage_flag,
	input  wire logic           overvoltage_flag,
	input  wire logic           overcurrent_flag,
	output logic                regulator_hot_warning,
	output fshr_pkg::fshr_hys_t hot_release_hysteresis_code
);
	import fshr_pkg::*;

	fshr_hot_if hot_bus ();

	fshr_hys_t  hys_code_r;
	logic       hot_flag_r;
	logic       hot_flag_nxt;
	logic       ocw_flag_r;
	logic       ocw_flag_nxt;
	logic       hot_warn_r;
	logic       hot_prev_r;
	logic       ocw_prev_r;
	logic       hot_rise;
	logic       ocw_rise;
	logic       wr_hys;
	logic       wr_fault;
	logic       rd_hit;
	logic [7:0] hys_byte;
	logic [7:0] fault_byte;
	logic [7:0] rdata_nxt;

	assign wr_hys   = reg_wr_en && (reg_addr == FSHR_HYS_OFFSET);
	assign wr_fault = reg_wr_en && (reg_addr == FSHR_FAULT_OFFSET);
	assign rd_hit   = reg_rd_en;

	// Hysteresis code register
	always_ff @(posedge clock) begin
		if (reset) begin
			hys_code_r <= FSHR_HYS_RESET;
		end else if (wr_hys) begin
			hys_code_r <= reg_wdata[FSHR_HYS_W-1:0];
		end
	end

	assign hot_release_hysteresis_code = hys_code_r;

	// Host-controlled comparator only runs while host control is set
	assign hot_bus.temperature = die_temperature_code;
	assign hot_bus.threshold   = hot_threshold_code;
	assign hot_bus.hys_code    = hys_code_r;
	assign hot_bus.enable      = hot_threshold_host_control;

	fshr_hot_compare u_hot_compare (
		.clock   (clock),
		.reset   (reset),
		.hot_bus (hot_bus.cmp)
	);

	// Warning source follows the selected threshold owner
	always_ff @(posedge clock) begin
		if (reset) begin
			hot_warn_r <= 1'b0;
		end else if (hot_threshold_host_control) begin
			hot_warn_r <= hot_bus.hot;
		end else begin
			hot_warn_r <= processor_hot_request;
		end
	end

	assign regulator_hot_warning = hot_warn_r;

	// Edge history for the sticky warnings
	always_ff @(posedge clock) begin
		if (reset) begin
			hot_prev_r <= 1'b0;
			ocw_prev_r <= 1'b0;
		end else begin
			hot_prev_r <= hot_warn_r;
			ocw_prev_r <= overcurrent_warning_event;
		end
	end

	assign hot_rise = hot_warn_r && !hot_prev_r;
	assign ocw_rise = overcurrent_warning_event && !ocw_prev_r;

	// Sticky flags: a new event wins over a same-cycle clear
	always_comb begin
		hot_flag_nxt = hot_flag_r;
		ocw_flag_nxt = ocw_flag_r;
		if (wr_fault && reg_wdata[FSHR_BIT_HOT]) begin
			hot_flag_nxt = 1'b0;
		end
		if (wr_fault && reg_wdata[FSHR_BIT_OCW]) begin
			ocw_flag_nxt = 1'b0;
		end
		if (hot_rise) begin
			hot_flag_nxt = 1'b1;
		end
		if (ocw_rise) begin
			ocw_flag_nxt = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			hot_flag_r <= 1'b0;
			ocw_flag_r <= 1'b0;
		end else begin
			hot_flag_r <= hot_flag_nxt;
			ocw_flag_r <= ocw_flag_nxt;
		end
	end

	// Read images
	assign hys_byte = {5'h00, hys_code_r};

	always_comb begin
		fault_byte = 8'h00;
		fault_byte[FSHR_BIT_RSVD] = 1'b0;
		fault_byte[FSHR_BIT_SSOC] = softstart_overcurrent_flag;
		fault_byte[FSHR_BIT_HOT]  = hot_flag_r;
		fault_byte[FSHR_BIT_OCW]  = ocw_flag_r;
		fault_byte[FSHR_BIT_OTP]  = overtemperature_flag;
		fault_byte[FSHR_BIT_UV]   = undervoltage_flag;
		fault_byte[FSHR_BIT_OV]   = overvoltage_flag;
		fault_byte[FSHR_BIT_OC]   = overcurrent_flag;
	end

	always_comb begin
		unique case (reg_addr)
			FSHR_HYS_OFFSET:   rdata_nxt = hys_byte;
			FSHR_FAULT_OFFSET: rdata_nxt = fault_byte;
			default:           rdata_nxt = FSHR_UNMAPPED;
		endcase
	end

	// Read data is captured on the same edge that samples the read strobe
	always_ff @(posedge clock) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (rd_hit) begin
			reg_rdata <= rdata_nxt;
		end
	end

	property p_hys_reset;
		@(posedge clock)
		reset |=> (hys_code_r == FSHR_HYS_RESET);
	endproperty
	a_hys_reset: assert property (p_hys_reset)
		else $error("hysteresis code not zero after reset");

	property p_hys_write;
		@(posedge clock) disable iff (reset)
		wr_hys |=> (hot_release_hysteresis_code == $past(reg_wdata[2:0]));
	endproperty
	a_hys_write: assert property (p_hys_write)
		else $error("hysteresis code did not take written value");

	property p_hys_read;
		@(posedge clock) disable iff (reset)
		(reg_rd_en && reg_addr == FSHR_HYS_OFFSET && !wr_hys)
			|=> (reg_rdata[7:3] == 5'h00)
			&& (reg_rdata[2:0] == hot_release_hysteresis_code);
	endproperty
	a_hys_read: assert property (p_hys_read)
		else $error("hysteresis read shows nonzero reserved bits");

	property p_fault_live;
		@(posedge clock) disable iff (reset)
		(reg_rd_en && reg_addr == FSHR_FAULT_OFFSET)
			|=> (reg_rdata[6] == $past(softstart_overcurrent_flag))
			&& (reg_rdata[3] == $past(overtemperature_flag))
			&& (reg_rdata[2] == $past(undervoltage_flag))
			&& (reg_rdata[1] == $past(overvoltage_flag))
			&& (reg_rdata[0] == $past(overcurrent_flag));
	endproperty
	a_fault_live: assert property (p_fault_live)
		else $error("fault read does not match live fault inputs");

	property p_fault_rsvd;
		@(posedge clock) disable iff (reset)
		(reg_rd_en && reg_addr == FSHR_FAULT_OFFSET) |=> !reg_rdata[7];
	endproperty
	a_fault_rsvd: assert property (p_fault_rsvd)
		else $error("fault reserved bit reads one");

	// A host clear right after the catch may drop the flag again
	property p_hot_flag_set;
		@(posedge clock) disable iff (reset)
		(regulator_hot_warning && !$past(regulator_hot_warning))
			|=> hot_flag_r
			##1 (hot_flag_r || $past(wr_fault && reg_wdata[FSHR_BIT_HOT]));
	endproperty
	a_hot_flag_set: assert property (p_hot_flag_set)
		else $error("hot flag not caught on warning rise");

	property p_ocw_clear;
		@(posedge clock) disable iff (reset)
		(wr_fault && reg_wdata[FSHR_BIT_OCW] && !ocw_rise) |=> !ocw_flag_r;
	endproperty
	a_ocw_clear: assert property (p_ocw_clear)
		else $error("overcurrent warning flag not cleared by write one");

	property p_ocw_set_wins;
		@(posedge clock) disable iff (reset)
		ocw_rise |=> ocw_flag_r;
	endproperty
	a_ocw_set_wins: assert property (p_ocw_set_wins)
		else $error("overcurrent warning rise lost against a clear");

	property p_zero_keeps;
		@(posedge clock) disable iff (reset)
		(wr_fault && !reg_wdata[FSHR_BIT_HOT] && hot_flag_r) |=> hot_flag_r;
	endproperty
	a_zero_keeps: assert property (p_zero_keeps)
		else $error("writing zero disturbed hot flag");

	property p_proc_owns_hot;
		@(posedge clock) disable iff (reset)
		(!hot_threshold_host_control ##1 !hot_threshold_host_control)
			|-> (regulator_hot_warning == $past(processor_hot_request));
	endproperty
	a_proc_owns_hot: assert property (p_proc_owns_hot)
		else $error("hot warning not following processor request");
endmodule

// file: verif/fshr_host_model.sv
// Host side of the register port: byte reads and writes
`timescale 1ns/100ps
module fshr_host_model (
	input  wire logic       clock,
	input  wire logic [7:0] reg_rdata,
	output logic      [7:0] reg_addr,
	output logic            reg_wr_en,
	output logic            reg_rd_en,
	output logic      [7:0] reg_wdata
);
	initial begin
		reg_addr  = 8'h00;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_wdata = 8'h00;
	end

	// One-cycle strobe; a one bit in the data clears a sticky flag
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge clock);
		reg_wr_en <= 1'b0;
		reg_wdata <= ~d;
		#1;
	endtask

	// Data is registered at the edge that takes the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_rd_en <= 1'b1;
		@(posedge clock);
		reg_rd_en <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the fault status and hot hysteresis registers
`timescale 1ns/100ps
module tb_top;
	import fshr_pkg::*;

	logic                clock;
	logic                reset;
	logic [7:0]          reg_addr;
	logic                reg_wr_en;
	logic                reg_rd_en;
	logic [7:0]          reg_wdata;
	logic [7:0]          reg_rdata;
	logic [7:0]          temp;
	logic [7:0]          thr;
	logic                hctl;
	logic                proc_hot;
	logic [7:0]          live;
	logic                ocw;
	logic                hot;
	fshr_hys_t           hys;
	logic [7:0]          d;
	int                  err_count;
	int                  tests_run;
	int                  pos [5] = '{0, 1, 2, 3, 6};

	fshr_host_model host (
		.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata)
	);

	fshr_regs DUT (
		.clock(clock), .reset(reset), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.die_temperature_code(temp), .hot_threshold_code(thr),
		.hot_threshold_host_control(hctl),
		.processor_hot_request(proc_hot),
		.softstart_overcurrent_flag(live[6]),
		.overcurrent_warning_event(ocw),
		.overtemperature_flag(live[3]), .undervoltage_flag(live[2]),
		.overvoltage_flag(live[1]), .overcurrent_flag(live[0]),
		.regulator_hot_warning(hot), .hot_release_hysteresis_code(hys)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic test_done;
		$display("Mismatches %0d of %0d checks", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#20us;
		err_count++;
		test_done();
	end

	initial begin
		err_count = 0;
		tests_run = 0;
		reset = 1'b1;
		temp = 8'h50;
		thr = 8'h64;
		hctl = 1'b0;
		proc_hot = 1'b0;
		live = 8'h00;
		ocw = 1'b0;
		cyc(20);
		reset <= 1'b0;
		host.rd(FSHR_HYS_OFFSET, d); chk(d, 8'h00);
		host.rd(FSHR_FAULT_OFFSET, d); chk(d, 8'h00);
		host.rd(8'h1B, d); chk(d, FSHR_UNMAPPED);
		host.wr(FSHR_HYS_OFFSET, 8'hFF);
		host.rd(FSHR_HYS_OFFSET, d); chk(d, 8'h07);
		chk({5'h00, hys}, 8'h07);
		// Each live fault appears alone at its own position
		foreach (pos[i]) begin
			live <= 8'h01 << pos[i];
			cyc(2);
			host.rd(FSHR_FAULT_OFFSET, d); chk(d, 8'h01 << pos[i]);
		end
		live <= 8'h4F;
		host.wr(FSHR_FAULT_OFFSET, 8'hFF);
		host.rd(FSHR_FAULT_OFFSET, d); chk(d, 8'h4F);
		live <= 8'h00;
		ocw <= 1'b1;
		cyc(3);
		ocw <= 1'b0;
		host.rd(FSHR_FAULT_OFFSET, d); chk(d, 8'h10);
		host.wr(FSHR_FAULT_OFFSET, 8'h00);
		host.rd(FSHR_FAULT_OFFSET, d); chk(d, 8'h10);
		host.wr(FSHR_FAULT_OFFSET, 8'h10);
		host.rd(FSHR_FAULT_OFFSET, d); chk(d, 8'h00);
		// Warning rise in the same cycle as a write-one clear keeps the flag
		fork
			host.wr(FSHR_FAULT_OFFSET, 8'h10);
			begin
				@(posedge clock);
				ocw <= 1'b1;
			end
		join
		host.rd(FSHR_FAULT_OFFSET, d); chk(d, 8'h10);
		ocw <= 1'b0;
		host.wr(FSHR_FAULT_OFFSET, 8'h10);
		host.rd(FSHR_FAULT_OFFSET, d); chk(d, 8'h00);
		proc_hot <= 1'b1;
		cyc(2); chk(hot, 1'b1);
		proc_hot <= 1'b0;
		cyc(3); chk(hot, 1'b0);
		host.rd(FSHR_FAULT_OFFSET, d); chk(d, 8'h20);
		host.wr(FSHR_FAULT_OFFSET, 8'h20);
		host.rd(FSHR_FAULT_OFFSET, d); chk(d, 8'h00);
		// Host control: code 1 gives 6 degrees of release hysteresis
		host.wr(FSHR_HYS_OFFSET, 8'h01);
		hctl <= 1'b1;
		proc_hot <= 1'b1;
		cyc(4); chk(hot, 1'b0);
		temp <= 8'h64;
		cyc(4); chk(hot, 1'b1);
		temp <= 8'h60;
		cyc(4); chk(hot, 1'b1);
		// Exactly threshold minus hysteresis still holds the warning
		temp <= 8'h5E;
		cyc(4); chk(hot, 1'b1);
		temp <= 8'h5D;
		cyc(4); chk(hot, 1'b0);
		temp <= 8'h64;
		thr <= FSHR_HOT_DISABLE;
		cyc(4); chk(hot, 1'b0);
		test_done();
	end
endmodule
